// ### rtl/adc_port_pkg.sv
package adc_port_pkg;

  // Register indices (printed offsets are not all multiples of four,
  // so they are indices and the byte address is four times the index).
  localparam logic [3:0] IDX_STATUS = 4'h0;
  localparam logic [3:0] IDX_CLOCK = 4'h3;
  localparam logic [3:0] IDX_PLAY_FMT = 4'h4;
  localparam logic [3:0] IDX_PLAY_DIV_HI = 4'h5;
  localparam logic [3:0] IDX_PLAY_DIV_LO = 4'h6;
  localparam logic [3:0] IDX_ADC_FMT = 4'h7;
  localparam logic [3:0] IDX_ADC_DIV_HI = 4'h8;
  localparam logic [3:0] IDX_ADC_DIV_LO = 4'h9;
  localparam logic [3:0] IDX_GAIN_GATE = 4'hA;
  localparam logic [3:0] IDX_HIGHPASS = 4'hB;
  localparam logic [3:0] IDX_AGC_CTRL = 4'hC;

  // Pin-function codes for the capture word-clock pin.
  localparam logic [1:0] PIN_GP_IN = 2'h0;
  localparam logic [1:0] PIN_WORD_CLK = 2'h1;
  localparam logic [1:0] PIN_OUT_LOW = 2'h2;
  localparam logic [1:0] PIN_OUT_HIGH = 2'h3;

  // Field positions.
  localparam int FMT_WCI = 7;
  localparam int FMT_BCI = 6;
  localparam int FMT_PIN_HI = 5;
  localparam int FMT_PIN_LO = 4;
  localparam int FMT_DLY = 3;
  localparam int PFMT_PCM = 2;
  localparam int PFMT_WS = 0;
  localparam int CLK_MASTER = 3;
  localparam int DIV_PLL = 7;

  // Gain and gate encodings.
  localparam logic [3:0] GAIN_MAX_CODE = 4'hD;
  localparam logic [3:0] GATE_FIRST_CODE = 4'h6;
  localparam int GATE_BASE_DB = 64;
  localparam int GATE_STEP_DB = 4;
  localparam int GATE_AGC_OFFSET_DB = 20;
  localparam int GAIN_TOP_DB = 3;

  // Frame and word sizes.
  localparam int PCM_BITS = 16;
  localparam int NARROW_BITS = 16;
  localparam int WIDE_BITS = 18;
  localparam int SAMPLE_W = 18;

  // Divider scale factor: word clock = div * pclk / (65536 * 96).
  localparam int DIV_SCALE = 96;
  localparam int DIV_W = 15;
  // The accumulator wraps once per bit-clock toggle with a doubled step.
  localparam int PHASE_W = 17;

  // Clock of the core.
  localparam int CORE_CLK_HZ = 40000000;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Stereo sample pair handed to the serializer.
  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } stereo_s;

endpackage : adc_port_pkg

// ### rtl/adc_audio_serial_port.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module adc_audio_serial_port #(
  parameter int ADDR_W = 6
) (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] S_AWADDR_IN,
  input wire logic S_AWVALID_IN,
  output logic S_AWREADY_OUT,
  input wire logic [31:0] S_WDATA_IN,
  input wire logic [3:0] S_WSTRB_IN,
  input wire logic S_WVALID_IN,
  output logic S_WREADY_OUT,
  output logic [1:0] S_BRESP_OUT,
  output logic S_BVALID_OUT,
  input wire logic S_BREADY_IN,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] S_ARADDR_IN,
  input wire logic S_ARVALID_IN,
  output logic S_ARREADY_OUT,
  output logic [31:0] S_RDATA_OUT,
  output logic [1:0] S_RRESP_OUT,
  output logic S_RVALID_OUT,
  input wire logic S_RREADY_IN,
  // Converter samples and AGC state.
  input wire logic [2*adc_port_pkg::SAMPLE_W-1:0] SAMPLE_IN,
  input wire logic AGC_AT_MAX_IN,
  // Serial pins; bit clock and word clocks are two-way.
  input wire logic BIT_CLK_IN,
  output logic BIT_CLK_OUT,
  output logic BIT_CLK_OE_OUT,
  input wire logic PLAY_WORD_CLK_IN,
  output logic PLAY_WORD_CLK_OUT,
  output logic PLAY_WORD_CLK_OE_OUT,
  input wire logic CAP_WORD_CLK_IN,
  output logic CAP_WORD_CLK_OUT,
  output logic CAP_WORD_CLK_OE_OUT,
  output logic SERIAL_CAPTURE_OUT,
  // Filter selections for the converter datapaths.
  output logic [2:0] CAPTURE_HIGHPASS_OUT,
  output logic [2:0] PLAYBACK_HIGHPASS_OUT
);

  localparam int SW = adc_port_pkg::SAMPLE_W;

  // Register images.
  logic [7:0] clock_ctrl_reg;
  logic [7:0] play_fmt_reg;
  logic [7:0] play_div_hi_reg;
  logic [7:0] play_div_lo_reg;
  logic [7:0] adc_port_format_reg;
  logic [7:0] adc_pll_and_divider_high_reg;
  logic [7:0] adc_divider_low_reg;
  logic [7:0] adc_gain_and_gate_reg;
  logic [7:0] highpass_select_reg;
  logic [7:0] agc_ctrl_reg;

  // Decoded fields.
  logic [1:0] adc_word_pin_function;
  logic own_clk;
  logic master;
  logic wci;
  logic bci;
  logic adc_data_delay;
  logic pcm_mode;
  logic sample_width_select;
  logic pll_on;
  logic [adc_port_pkg::DIV_W-1:0] rate_div;

  // Register index of a bus address; the low two bits are ignored.
  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[5:2];
  endfunction : reg_index

  assign adc_word_pin_function =
    adc_port_format_reg[adc_port_pkg::FMT_PIN_HI:adc_port_pkg::FMT_PIN_LO];
  // Capture pin only acts as its own word clock in code 01.
  assign own_clk = (adc_word_pin_function == adc_port_pkg::PIN_WORD_CLK);
  assign master = clock_ctrl_reg[adc_port_pkg::CLK_MASTER];
  assign wci = adc_port_format_reg[adc_port_pkg::FMT_WCI];
  // Master mode times output on the playback edge setting.
  assign bci = master ? play_fmt_reg[adc_port_pkg::FMT_BCI]
                      : adc_port_format_reg[adc_port_pkg::FMT_BCI];
  assign adc_data_delay = adc_port_format_reg[adc_port_pkg::FMT_DLY];
  assign pcm_mode = play_fmt_reg[adc_port_pkg::PFMT_PCM];
  assign sample_width_select = play_fmt_reg[adc_port_pkg::PFMT_WS];
  // Shared clocking borrows playback PLL and divider settings.
  assign pll_on = own_clk
    ? adc_pll_and_divider_high_reg[adc_port_pkg::DIV_PLL]
    : play_div_hi_reg[adc_port_pkg::DIV_PLL];
  assign rate_div = own_clk
    ? {adc_pll_and_divider_high_reg[6:0], adc_divider_low_reg}
    : {play_div_hi_reg[6:0], play_div_lo_reg};

  // Pin synchronisers: three stages, change accepted when last two agree.
  logic [2:0] bclk_sync_reg;
  logic [2:0] pwc_sync_reg;
  logic [2:0] cwc_sync_reg;
  logic bclk_level_reg;
  logic pwc_level_reg;
  logic cwc_level_reg;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      bclk_sync_reg <= 3'h0;
      pwc_sync_reg <= 3'h0;
      cwc_sync_reg <= 3'h0;
      bclk_level_reg <= 1'b0;
      pwc_level_reg <= 1'b0;
      cwc_level_reg <= 1'b0;
    end
    else
    begin
      bclk_sync_reg <= {bclk_sync_reg[1:0], BIT_CLK_IN};
      pwc_sync_reg <= {pwc_sync_reg[1:0], PLAY_WORD_CLK_IN};
      cwc_sync_reg <= {cwc_sync_reg[1:0], CAP_WORD_CLK_IN};
      if (bclk_sync_reg[1] == bclk_sync_reg[2])
      begin
        bclk_level_reg <= bclk_sync_reg[2];
      end
      if (pwc_sync_reg[1] == pwc_sync_reg[2])
      begin
        pwc_level_reg <= pwc_sync_reg[2];
      end
      if (cwc_sync_reg[1] == cwc_sync_reg[2])
      begin
        cwc_level_reg <= cwc_sync_reg[2];
      end
    end
  end

  // Master timing: a phase accumulator gives the word-clock rate and the
  // bit clock runs at 48 times it. The 48x bit clock needs the word rate
  // well below core/96; at 40 MHz that caps near 400 kHz, far above 48 kHz.
  logic [adc_port_pkg::PHASE_W-1:0] phase_reg;
  logic [adc_port_pkg::PHASE_W-1:0] phase_next;
  logic gen_bclk_reg;
  logic gen_wclk_reg;
  logic [5:0] gen_bit_cnt_reg;

  // Step of 2*65536*96*f/fclk, scaled so 96 bit-clock halves... per word.
  assign phase_next = phase_reg +
    adc_port_pkg::PHASE_W'({rate_div, 1'b0});

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      phase_reg <= '0;
      gen_bclk_reg <= 1'b0;
      gen_wclk_reg <= 1'b0;
      gen_bit_cnt_reg <= 6'h00;
    end
    else if (master)
    begin
      phase_reg <= phase_next;
      // Each accumulator wrap toggles the bit clock; 96 toggles per word.
      if (phase_next[adc_port_pkg::PHASE_W-1] != phase_reg[adc_port_pkg::PHASE_W-1] &&
          !phase_next[adc_port_pkg::PHASE_W-1])
      begin
        gen_bclk_reg <= ~gen_bclk_reg;
        // Word clock moves with the bit-clock edge chosen by invert.
        // Bit clock high here means this toggle is a falling edge.
        if (gen_bclk_reg != bci)
        begin
          if (gen_bit_cnt_reg == 6'h17)
          begin
            gen_bit_cnt_reg <= 6'h00;
            gen_wclk_reg <= ~gen_wclk_reg;
          end
          else
          begin
            gen_bit_cnt_reg <= gen_bit_cnt_reg + 6'h01;
          end
        end
      end
    end
  end

  // Effective serial clocks seen by the capture shifter.
  logic bclk_now;
  logic wclk_now;
  assign bclk_now = master ? gen_bclk_reg : bclk_level_reg;
  // Shared mode frames capture data from the playback word clock.
  assign wclk_now = master ? gen_wclk_reg
                  : (own_clk ? cwc_level_reg : pwc_level_reg);

  // Digital gain and noise gate on the captured pair.
  function automatic logic [SW-1:0] scale(input logic [SW-1:0] s,
                                          input logic [4:0] att_db);
    logic signed [SW+1:0] x;
    logic signed [SW+1:0] y;
    int i;
    x = {{2{s[SW-1]}}, s};
    y = x;
    // Each 6 dB halves; single dB steps use 7/8 per dB approximation.
    for (i = 0; i < att_db / 6; i++)
    begin
      y = y >>> 1;
    end
    for (i = 0; i < att_db % 6; i++)
    begin
      y = y - (y >>> 3);
    end
    scale = y[SW-1:0];
  endfunction : scale

  logic [3:0] adc_output_gain;
  logic [3:0] noise_gate_threshold;
  logic [4:0] gain_att_db;
  logic [7:0] gate_db;
  logic [7:0] level_db;
  logic [7:0] gate_att_db;
  adc_port_pkg::stereo_s raw_pair;
  adc_port_pkg::stereo_s out_pair;
  logic [SW-1:0] mag;
  logic [4:0] lead_zero;

  assign adc_output_gain = adc_gain_and_gate_reg[7:4];
  assign noise_gate_threshold = adc_gain_and_gate_reg[3:0];
  assign raw_pair = SAMPLE_IN;
  // Gain codes past 0xD clamp at -10 dB; +3 dB reference is 3 dB above.
  assign gain_att_db = (adc_output_gain > adc_port_pkg::GAIN_MAX_CODE)
    ? 5'(adc_port_pkg::GAIN_MAX_CODE) : 5'(adc_output_gain);

  // Rough level below full scale: 6 dB per leading zero of the magnitude.
  assign mag = raw_pair.left[SW-1] ? ~raw_pair.left : raw_pair.left;
  always_comb
  begin
    lead_zero = 5'(SW);
    for (int k = 0; k < SW; k++)
    begin
      if (mag[k])
      begin
        lead_zero = 5'(SW - 1 - k);
      end
    end
  end
  assign level_db = 8'(6 * lead_zero) + 8'(gain_att_db)
                  - 8'(adc_port_pkg::GAIN_TOP_DB);
  // Threshold depth in dB below full scale, 20 dB less under AGC.
  assign gate_db = 8'(adc_port_pkg::GATE_BASE_DB) - 8'(adc_port_pkg::GATE_STEP_DB *
    (noise_gate_threshold - adc_port_pkg::GATE_FIRST_CODE))
    - (agc_ctrl_reg[1:0] != 2'h0 ? 8'(adc_port_pkg::GATE_AGC_OFFSET_DB) : 8'h00);
  always_comb
  begin
    gate_att_db = 8'h00;
    if (noise_gate_threshold >= adc_port_pkg::GATE_FIRST_CODE &&
        (agc_ctrl_reg[1:0] == 2'h0 || AGC_AT_MAX_IN) &&
        level_db > gate_db)
    begin
      gate_att_db = (level_db - gate_db) >> 1;
    end
  end

  // Gain stage result; the +3 dB top code needs headroom we do not have,
  // so codes 0..3 saturate at unity instead of boosting.
  logic [4:0] total_att;
  assign total_att = ((gain_att_db < 5'h3) ? 5'h0 : gain_att_db - 5'h3)
                   + ((gate_att_db > 8'h10) ? 5'h10 : gate_att_db[4:0]);
  assign out_pair.left = scale(raw_pair.left, total_att);
  assign out_pair.right = scale(raw_pair.right, total_att);

  // Capture shifter, walks one bit per bit-clock period.
  logic bclk_prev_reg;
  logic wclk_prev_reg;
  logic [SW-1:0] shift_reg;
  logic [SW-1:0] hold_right_reg;
  logic [5:0] bit_cnt_reg;
  logic out_bit_reg;
  logic load_left;
  logic [SW-1:0] load_word;
  logic launch_edge;
  logic wclk_edge;
  logic frame_edge;
  logic [4:0] word_bits;

  assign launch_edge = (bclk_prev_reg != bclk_now) && (bclk_now == bci);
  assign wclk_edge = (wclk_prev_reg != wclk_now);
  // Pulse mode frames on one chosen edge only.
  assign frame_edge = wclk_edge && (!pcm_mode || (wclk_now == wci));
  assign word_bits = pcm_mode ? 5'(adc_port_pkg::PCM_BITS)
    : (sample_width_select ? 5'(adc_port_pkg::WIDE_BITS)
                           : 5'(adc_port_pkg::NARROW_BITS));
  // A frame edge starts the left word in pulse mode or in the left state.
  assign load_left = pcm_mode || (wclk_now == wci);
  // Samples go out MSB-justified: a 16-bit word drops the two LSBs.
  assign load_word = load_left ? out_pair.left : hold_right_reg;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      bclk_prev_reg <= 1'b0;
      wclk_prev_reg <= 1'b0;
      shift_reg <= '0;
      hold_right_reg <= '0;
      bit_cnt_reg <= 6'h00;
      out_bit_reg <= 1'b0;
    end
    else
    begin
      bclk_prev_reg <= bclk_now;
      wclk_prev_reg <= wclk_now;
      if (frame_edge)
      begin
        // Left when word clock level matches invert (low with invert 0), else right; always left in pulse mode.
        if (load_left)
        begin
          hold_right_reg <= out_pair.right;
        end
        // Delay is ignored in pulse mode; the delay slot is one launch edge.
        if (adc_data_delay && !pcm_mode)
        begin
          shift_reg <= load_word;
          bit_cnt_reg <= 6'h00;
        end
        else
        begin
          // The MSB must already stand at the first sampling edge, and a
          // launch edge that falls with the frame edge is this one.
          out_bit_reg <= load_word[SW-1];
          shift_reg <= load_word << 1;
          bit_cnt_reg <= 6'h01;
        end
      end
      else if (launch_edge)
      begin
        if (pcm_mode && bit_cnt_reg == 6'(adc_port_pkg::PCM_BITS))
        begin
          // Right channel follows left with no gap.
          out_bit_reg <= hold_right_reg[SW-1];
          shift_reg <= hold_right_reg << 1;
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
        else if (bit_cnt_reg < 6'(word_bits) ||
                 (pcm_mode && bit_cnt_reg < 6'(2 * adc_port_pkg::PCM_BITS)))
        begin
          out_bit_reg <= shift_reg[SW-1];
          shift_reg <= shift_reg << 1;
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
        else
        begin
          out_bit_reg <= 1'b0;
        end
      end
    end
  end

  // Pin drivers.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      SERIAL_CAPTURE_OUT <= 1'b0;
      BIT_CLK_OUT <= 1'b0;
      BIT_CLK_OE_OUT <= 1'b0;
      PLAY_WORD_CLK_OUT <= 1'b0;
      PLAY_WORD_CLK_OE_OUT <= 1'b0;
      CAP_WORD_CLK_OUT <= 1'b0;
      CAP_WORD_CLK_OE_OUT <= 1'b0;
      CAPTURE_HIGHPASS_OUT <= 3'h0;
      PLAYBACK_HIGHPASS_OUT <= 3'h0;
    end
    else
    begin
      SERIAL_CAPTURE_OUT <= out_bit_reg;
      BIT_CLK_OUT <= gen_bclk_reg;
      BIT_CLK_OE_OUT <= master;
      PLAY_WORD_CLK_OUT <= gen_wclk_reg;
      PLAY_WORD_CLK_OE_OUT <= master;
      // Code 00 leaves the pin an input; 10 and 11 drive a level.
      unique case (adc_word_pin_function)
        adc_port_pkg::PIN_GP_IN:
        begin
          CAP_WORD_CLK_OUT <= 1'b0;
          CAP_WORD_CLK_OE_OUT <= 1'b0;
        end
        adc_port_pkg::PIN_WORD_CLK:
        begin
          CAP_WORD_CLK_OUT <= gen_wclk_reg;
          CAP_WORD_CLK_OE_OUT <= master;
        end
        adc_port_pkg::PIN_OUT_LOW:
        begin
          CAP_WORD_CLK_OUT <= 1'b0;
          CAP_WORD_CLK_OE_OUT <= 1'b1;
        end
        adc_port_pkg::PIN_OUT_HIGH:
        begin
          CAP_WORD_CLK_OUT <= 1'b1;
          CAP_WORD_CLK_OE_OUT <= 1'b1;
        end
      endcase
      // Code 000 bypasses; the datapath filter reads these.
      CAPTURE_HIGHPASS_OUT <= highpass_select_reg[6:4];
      PLAYBACK_HIGHPASS_OUT <= highpass_select_reg[2:0];
    end
  end

  // AXI4-Lite write: address and data taken in either order.
  logic aw_have_reg;
  logic w_have_reg;
  logic [3:0] aw_idx_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_idx_reg <= 4'h0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      S_AWREADY_OUT <= 1'b0;
      S_WREADY_OUT <= 1'b0;
      S_BVALID_OUT <= 1'b0;
      S_BRESP_OUT <= adc_port_pkg::RESP_OKAY;
      clock_ctrl_reg <= 8'h00;
      play_fmt_reg <= 8'h00;
      play_div_hi_reg <= 8'h00;
      play_div_lo_reg <= 8'h00;
      adc_port_format_reg <= 8'h00;
      adc_pll_and_divider_high_reg <= 8'h00;
      adc_divider_low_reg <= 8'h00;
      adc_gain_and_gate_reg <= 8'h00;
      highpass_select_reg <= 8'h00;
      agc_ctrl_reg <= 8'h00;
    end
    else
    begin
      S_AWREADY_OUT <= !aw_have_reg && !S_AWREADY_OUT && !S_BVALID_OUT;
      S_WREADY_OUT <= !w_have_reg && !S_WREADY_OUT && !S_BVALID_OUT;
      if (S_AWVALID_IN && S_AWREADY_OUT)
      begin
        aw_have_reg <= 1'b1;
        aw_idx_reg <= reg_index(S_AWADDR_IN);
      end
      if (S_WVALID_IN && S_WREADY_OUT)
      begin
        w_have_reg <= 1'b1;
        w_byte_reg <= S_WDATA_IN[7:0];
        w_lane_reg <= S_WSTRB_IN[0];
      end
      if (aw_have_reg && w_have_reg && !S_BVALID_OUT)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        S_BVALID_OUT <= 1'b1;
        S_BRESP_OUT <= adc_port_pkg::RESP_OKAY;
        if (w_lane_reg)
        begin
          unique case (aw_idx_reg)
            adc_port_pkg::IDX_CLOCK: clock_ctrl_reg <= w_byte_reg & 8'h7F;
            adc_port_pkg::IDX_PLAY_FMT: play_fmt_reg <= w_byte_reg;
            adc_port_pkg::IDX_PLAY_DIV_HI: play_div_hi_reg <= w_byte_reg;
            adc_port_pkg::IDX_PLAY_DIV_LO: play_div_lo_reg <= w_byte_reg;
            adc_port_pkg::IDX_ADC_FMT: adc_port_format_reg <= w_byte_reg & 8'hF8;
            adc_port_pkg::IDX_ADC_DIV_HI:
              adc_pll_and_divider_high_reg <= w_byte_reg;
            adc_port_pkg::IDX_ADC_DIV_LO: adc_divider_low_reg <= w_byte_reg;
            adc_port_pkg::IDX_GAIN_GATE: adc_gain_and_gate_reg <= w_byte_reg;
            adc_port_pkg::IDX_HIGHPASS: highpass_select_reg <= w_byte_reg & 8'h77;
            adc_port_pkg::IDX_AGC_CTRL: agc_ctrl_reg <= w_byte_reg & 8'h7F;
            default: S_BRESP_OUT <= adc_port_pkg::RESP_SLVERR;
          endcase
        end
      end
      else if (S_BVALID_OUT && S_BREADY_IN)
      begin
        S_BVALID_OUT <= 1'b0;
      end
    end
  end

  // AXI4-Lite read; status index shows the sampled pin level while the pin function is code 00.
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      S_ARREADY_OUT <= 1'b0;
      S_RVALID_OUT <= 1'b0;
      S_RDATA_OUT <= 32'h00000000;
      S_RRESP_OUT <= adc_port_pkg::RESP_OKAY;
    end
    else
    begin
      S_ARREADY_OUT <= !S_ARREADY_OUT && !S_RVALID_OUT;
      if (S_ARVALID_IN && S_ARREADY_OUT)
      begin
        S_RVALID_OUT <= 1'b1;
        S_RRESP_OUT <= adc_port_pkg::RESP_OKAY;
        unique case (reg_index(S_ARADDR_IN))
          adc_port_pkg::IDX_STATUS: S_RDATA_OUT <= {31'h0,
            adc_word_pin_function == adc_port_pkg::PIN_GP_IN && cwc_level_reg};
          adc_port_pkg::IDX_CLOCK: S_RDATA_OUT <= {24'h0, clock_ctrl_reg};
          adc_port_pkg::IDX_PLAY_FMT: S_RDATA_OUT <= {24'h0, play_fmt_reg};
          adc_port_pkg::IDX_PLAY_DIV_HI: S_RDATA_OUT <= {24'h0, play_div_hi_reg};
          adc_port_pkg::IDX_PLAY_DIV_LO: S_RDATA_OUT <= {24'h0, play_div_lo_reg};
          adc_port_pkg::IDX_ADC_FMT: S_RDATA_OUT <= {24'h0, adc_port_format_reg};
          adc_port_pkg::IDX_ADC_DIV_HI:
            S_RDATA_OUT <= {24'h0, adc_pll_and_divider_high_reg};
          adc_port_pkg::IDX_ADC_DIV_LO: S_RDATA_OUT <= {24'h0, adc_divider_low_reg};
          adc_port_pkg::IDX_GAIN_GATE: S_RDATA_OUT <= {24'h0, adc_gain_and_gate_reg};
          adc_port_pkg::IDX_HIGHPASS: S_RDATA_OUT <= {24'h0, highpass_select_reg};
          adc_port_pkg::IDX_AGC_CTRL: S_RDATA_OUT <= {24'h0, agc_ctrl_reg};
          default:
          begin
            S_RDATA_OUT <= 32'h00000000;
            S_RRESP_OUT <= adc_port_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (S_RVALID_OUT && S_RREADY_IN)
      begin
        S_RVALID_OUT <= 1'b0;
      end
    end
  end

  // The PLL enable bit is decoded but drives nothing, so no lock state
  // is held; master timing uses the divider whether or not it is set.
  logic unused_pll;
  assign unused_pll = pll_on;

endmodule : adc_audio_serial_port

`default_nettype wire

// ### testbench/adc_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Bus and pin checks; sees only the port's own pins.
module adc_port_asserts #(
  parameter int ADDR_W = 6
) (
  input wire logic CORE_CLK_IN, RST_B_IN,
  input wire logic S_AWVALID_IN, S_AWREADY_OUT, S_WVALID_IN, S_WREADY_OUT,
  input wire logic S_BVALID_OUT, S_BREADY_IN, S_ARVALID_IN, S_ARREADY_OUT,
  input wire logic S_RVALID_OUT, S_RREADY_IN,
  input wire logic [1:0] S_BRESP_OUT, S_RRESP_OUT,
  input wire logic [ADDR_W-1:0] S_ARADDR_IN,
  input wire logic [31:0] S_RDATA_OUT,
  input wire logic BIT_CLK_OE_OUT, PLAY_WORD_CLK_OE_OUT,
  input wire logic [2:0] CAPTURE_HIGHPASS_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Handshakes taken at this edge.
  wire ar = S_ARVALID_IN && S_ARREADY_OUT;
  wire aw = S_AWVALID_IN && S_AWREADY_OUT && S_WVALID_IN && S_WREADY_OUT;
  bvalid_hold_a: assert property (S_BVALID_OUT && !S_BREADY_IN
    |=> S_BVALID_OUT && $stable(S_BRESP_OUT)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (S_RVALID_OUT && !S_RREADY_IN
    |=> S_RVALID_OUT && $stable(S_RDATA_OUT)) else $error("rvalid dropped");
  read_answer_a: assert property (ar |=> S_RVALID_OUT)
    else $error("read answer late");
  write_answer_a: assert property (aw |-> ##[1:2] S_BVALID_OUT)
    else $error("write answer late");
  unmapped_read_a: assert property (ar && S_ARADDR_IN[5:2] > 4'hC
    |=> S_RRESP_OUT == 2'h2 && S_RDATA_OUT == 32'h0)
    else $error("unmapped read not refused");
  mapped_read_a: assert property (ar && S_ARADDR_IN[5:2] == 4'h7
    |=> S_RRESP_OUT == 2'h0) else $error("mapped read refused");
  master_oe_a: assert property (BIT_CLK_OE_OUT == PLAY_WORD_CLK_OE_OUT)
    else $error("clock enables disagree");
  highpass_hold_a: assert property ($changed(CAPTURE_HIGHPASS_OUT)
    |-> $past(S_BVALID_OUT))
    else $error("highpass moved without write");
  cover property (ar);
  cover property (aw);
  cover property ($changed(CAPTURE_HIGHPASS_OUT));
endmodule : adc_port_asserts
bind adc_audio_serial_port adc_port_asserts #(.ADDR_W(ADDR_W))
  u_adc_port_asserts (.*);
`default_nettype wire

// ### testbench/host_audio_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor as clock master; the clock runs only while grab shifts a frame.
module host_audio_model (
  output logic bit_clk_out,
  output logic word_clk_out,
  input wire logic sdata_in
);
  initial
  begin
    bit_clk_out = 1'b0;
    word_clk_out = 1'b1;
  end
  // Word clock moves on the falling edge, data is taken on the rising one.
  task automatic grab(output logic [31:0] word);
    for (int i = 0; i < 32; i++)
    begin
      word_clk_out = (i >= 16);
      #200 bit_clk_out = 1'b1;
      word = {word[30:0], sdata_in};
      #200 bit_clk_out = 1'b0;
    end
  endtask : grab
endmodule : host_audio_model
`default_nettype wire

// ### testbench/tb_adc_audio_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_audio_serial_port;
  logic clk, rst_b, awv, wv, bv, bry, arv, rv, rry, awr, wr_r, arr;
  logic bclk, pwc, lvl, c_oe, c_out, sd, b_oe;
  logic [5:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr;
  logic [2:0] hpc, hpp;
  int n_errors = 0;
  int compares = 0;
  // The shared pin reads back the device whenever it drives it.
  wire c_pin = c_oe ? c_out : lvl;
  adc_audio_serial_port u_adc_audio_serial_port (.CORE_CLK_IN(clk),
    .RST_B_IN(rst_b), .S_AWADDR_IN(awa), .S_AWVALID_IN(awv),
    .S_AWREADY_OUT(awr), .S_WDATA_IN(wd), .S_WSTRB_IN(4'hF),
    .S_WVALID_IN(wv), .S_WREADY_OUT(wr_r), .S_BRESP_OUT(br),
    .S_BVALID_OUT(bv), .S_BREADY_IN(bry), .S_ARADDR_IN(ara),
    .S_ARVALID_IN(arv), .S_ARREADY_OUT(arr), .S_RDATA_OUT(rdat),
    .S_RRESP_OUT(rr), .S_RVALID_OUT(rv), .S_RREADY_IN(rry),
    .SAMPLE_IN({18'h2B4D8, 18'h1234C}), .AGC_AT_MAX_IN(1'b0),
    .BIT_CLK_IN(bclk), .BIT_CLK_OUT(), .BIT_CLK_OE_OUT(b_oe),
    .PLAY_WORD_CLK_IN(pwc), .PLAY_WORD_CLK_OUT(), .PLAY_WORD_CLK_OE_OUT(),
    .CAP_WORD_CLK_IN(c_pin), .CAP_WORD_CLK_OUT(c_out),
    .CAP_WORD_CLK_OE_OUT(c_oe), .SERIAL_CAPTURE_OUT(sd),
    .CAPTURE_HIGHPASS_OUT(hpc), .PLAYBACK_HIGHPASS_OUT(hpp));
  host_audio_model u_host_audio_model (.bit_clk_out(bclk),
    .word_clk_out(pwc), .sdata_in(sd));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Address and data are each held until their own ready, and bry until bv, then released.
  task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    awa <= {idx, 2'b00}; wd <= {24'h0, d};
    awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    fork
      begin do @(posedge clk); while (awr !== 1'b1); awv <= 1'b0; end
      begin do @(posedge clk); while (wr_r !== 1'b1); wv <= 1'b0; end
      begin do @(posedge clk); while (bv !== 1'b1); bry <= 1'b0; end
    join
    repeat (2) @(posedge clk);
  endtask : wreg
  task automatic rreg(input logic [3:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
    @(posedge clk);
    ara <= {idx, 2'b00}; arv <= 1'b1; rry <= 1'b1;
    fork
      begin do @(posedge clk); while (arr !== 1'b1); arv <= 1'b0; end
      begin do @(posedge clk); while (rv !== 1'b1); rry <= 1'b0;
        d = rdat; r = rr; end
    join
  endtask : rreg
  // Pin functions, status level, filter selections and refusal.
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    wreg(4'hB, 8'h53);
    chk({hpc, hpp}, 6'h2B);
    wreg(4'h3, 8'h08);
    chk(b_oe, 1'b1);
    wreg(4'h3, 8'h00);
    chk(b_oe, 1'b0);
    rreg(4'hE, d, r);
    chk(r, 2'h2);
    wreg(4'h7, 8'h20);
    chk({c_oe, c_out}, 2'h2);
    wreg(4'h7, 8'h30);
    chk({c_oe, c_out}, 2'h3);
    rreg(4'h7, d, r);
    chk(d, 32'h30);
    wreg(4'h7, 8'h00);
    for (int v = 0; v < 2; v++)
    begin
      lvl <= v[0];
      repeat (8) @(posedge clk);
      rreg(4'h0, d, r);
      chk({c_oe, d[0]}, {1'b0, v[0]});
    end
  endtask : t_regs
  // Second of two back-to-back frames on the shared word clock.
  task automatic t_serial(input logic [7:0] f, input logic [31:0] m,
                          input logic [31:0] exp);
    logic [31:0] w;
    wreg(4'h7, f);
    u_host_audio_model.grab(w);
    u_host_audio_model.grab(w);
    chk(w & m, exp);
  endtask : t_serial
  task automatic test_done;
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  initial
  begin
    {rst_b, awv, wv, bry, arv, rry, lvl, awa, ara, wd} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_serial(8'h00, 32'hFFFFFFFF, 32'hAD3648D3);
    t_serial(8'h80, 32'hFFFFFFFF, 32'h48D3AD36);
    t_serial(8'h08, 32'h7FFF7FFF, 32'h569B2469);
    // Gain code 9 is -6 dB, half scale; AGC below max keeps the gate off.
    wreg(4'hC, 8'h01);
    wreg(4'hA, 8'h9A);
    t_serial(8'h00, 32'hFFFFFFFF, 32'hD69B2469);
    test_done;
  end
  // A hang past the expected run counts as a mismatch.
  initial
  begin
    #400000;
    n_errors++;
    test_done;
  end
endmodule : tb_adc_audio_serial_port
`default_nettype wire
